// ===== pkg/asfc_pkg.sv
// Constants and carrier types for the sample buffer control block.
// Assumes a 32-bit AXI4-Lite register bus and a 125 MHz core clock.
package asfc_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int IDX_W  = 10;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h03A;
    localparam logic [IDX_W-1:0] IDX_FLAGS    = 10'h03B;
    localparam logic [IDX_W-1:0] IDX_CONV     = 10'h03C;
    localparam logic [IDX_W-1:0] IDX_STREAM   = 10'h03D;
    localparam logic [IDX_W-1:0] IDX_IRQ_ST   = 10'h03E;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h03F;

    // Control register layout
    localparam int               CTRL_W       = 24;
    localparam logic [23:0]      CTRL_RESET   = 24'h040200;
    localparam logic [23:0]      CTRL_WR_MASK = 24'h0FFFFF;
    localparam int               CTRL_STATUS  = 19;
    localparam int               CTRL_TAG     = 18;
    localparam int               CTRL_MODE_HI = 17;
    localparam int               CTRL_MODE_LO = 16;
    localparam int               CTRL_WM_HI   = 7;
    localparam int               CTRL_WM_LO   = 0;
    localparam logic [1:0]       MODE_OFF     = 2'h0;
    localparam logic [1:0]       MODE_WMARK   = 2'h1;

    // Buffer flag word layout
    localparam int               FLAG_EMPTY   = 0;
    localparam int               FLAG_WMARK   = 1;
    localparam int               FLAG_LOST    = 2;
    localparam logic [7:0]       FLAGS_RESET  = 8'h01;

    // Interrupt status and mask layout
    localparam int               IRQ_W        = 2;
    localparam int               IRQ_WMARK    = 0;
    localparam int               IRQ_LOST     = 1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Readback stream position within one buffer read command
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_TAG,
        PH_DATA
    } asfc_phase_t;

    // AXI4-Lite slave side
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } asfc_axi_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } asfc_axi_rsp_t;

endpackage : asfc_pkg

// ===== design/asfc_sample_buffer.sv
// Sample buffer control: mode select, keep/drop policy, overrun flag,
// tagged readback stream, AXI4-Lite register slave and one interrupt.
// Assumes conversions arrive as one-cycle strobes synchronous to core_clk.
//
// Function
// RQ1: Mode 00 bypasses buffer; reset state.
// RQ2: Watermark mode keeps first N, drops rest.
// RQ3: Host read removes sample from buffer.
// RQ4: Watermark drop sets lost sample flag.
// RQ5: Streaming mode always keeps newest conversions.
// RQ6: Streaming full: drop oldest, set lost flag.
// RQ7: Tag bit prepends tag per sample.
// RQ8: Status bit prepends flag word once.
// RQ9: Both bits: one flag word, then pairs.
// RQ10: Target 0x00 means full depth 256.
// RQ11: Error/threshold flags only in active modes.
// RQ12: Host writes reserved bits zero, reads zero; ctrl bits 15:8 are stored and read back, and bit 9 resets to 1.
`timescale 1ns/1ps
`default_nettype none

module asfc_sample_buffer #(
    parameter int DEPTH  = 256,
    parameter int SMP_W  = 24,
    parameter int TAG_W  = 8
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // Register bus
    input  wire asfc_pkg::asfc_axi_req_t axi_req,
    output logic                         axi_awready,
    output logic                         axi_wready,
    output logic                         axi_bvalid,
    output logic [1:0]                   axi_bresp,
    output logic                         axi_arready,
    output logic                         axi_rvalid,
    output logic [31:0]                  axi_rdata,
    output logic [1:0]                   axi_rresp,
    // Conversion input
    input  wire logic                    conv_valid,
    input  wire logic [SMP_W-1:0]        conv_data,
    input  wire logic [TAG_W-1:0]        conv_tag,
    // Interrupt
    output logic                         irq
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam int ENT_W = TAG_W + SMP_W;

    initial begin
        if (DEPTH < 256 || DEPTH != (1 << PTR_W) || SMP_W > 32 || TAG_W > 32 || SMP_W < 1
            || TAG_W < 1) begin
            $error("asfc_sample_buffer: unsupported DEPTH, SMP_W or TAG_W");
        end
    end

    typedef struct packed {
        logic [asfc_pkg::CTRL_W-1:0]     ctrl;
        logic [DEPTH-1:0][ENT_W-1:0]     mem;
        logic [PTR_W-1:0]                wr_ptr;
        logic [PTR_W-1:0]                rd_ptr;
        logic [CNT_W-1:0]                count;
        logic                            lock;
        logic                            lost;
        asfc_pkg::asfc_phase_t           phase;
        logic [asfc_pkg::IRQ_W-1:0]      irq_st;
        logic [asfc_pkg::IRQ_W-1:0]      irq_mask;
        logic [SMP_W-1:0]                conv;
        logic                            aw_have;
        logic [asfc_pkg::ADDR_W-1:0]     aw_addr;
        logic                            w_have;
        logic [31:0]                     w_data;
        logic [3:0]                      w_strb;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            rvalid;
        logic [31:0]                     rdata;
        logic [1:0]                      rresp;
    } asfc_state_t;

    asfc_state_t s_q;
    asfc_state_t s_d;

    // Word index of an aligned address
    function automatic logic [asfc_pkg::IDX_W-1:0] reg_idx(
        input logic [asfc_pkg::ADDR_W-1:0] addr
    );
        reg_idx = addr[asfc_pkg::ADDR_W-1:2];
    endfunction : reg_idx

    function automatic logic is_mapped(input logic [asfc_pkg::ADDR_W-1:0] addr);
        logic [asfc_pkg::IDX_W-1:0] i;
        i = reg_idx(addr);
        is_mapped = (addr[1:0] == 2'h0)
                    && (i >= asfc_pkg::IDX_CTRL) && (i <= asfc_pkg::IDX_IRQ_MASK);
    endfunction : is_mapped

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        lane_merge = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                lane_merge[8*b +: 8] = new_v[8*b +: 8];
            end
        end
    endfunction : lane_merge

    // Decoded control and derived levels
    logic [1:0]       mode;
    logic             active;
    logic             streaming;
    logic [7:0]       wm;
    logic [CNT_W-1:0] target;
    logic             full;
    logic             empty;
    logic [7:0]       flag_word;
    logic [ENT_W-1:0] head;
    logic             ar_hs;
    logic             aw_hs;
    logic             w_hs;
    logic             do_write;
    logic [asfc_pkg::IDX_W-1:0] wr_idx;
    logic [asfc_pkg::IDX_W-1:0] rd_idx;

    always_comb begin
        mode      = s_q.ctrl[asfc_pkg::CTRL_MODE_HI:asfc_pkg::CTRL_MODE_LO];
        active    = (mode != asfc_pkg::MODE_OFF);
        streaming = mode[1];
        wm        = s_q.ctrl[asfc_pkg::CTRL_WM_HI:asfc_pkg::CTRL_WM_LO];
        target    = (wm == 8'h00) ? CNT_W'(256) : CNT_W'(wm); // see RQ10
        full      = (s_q.count == CNT_W'(DEPTH));
        empty     = (s_q.count == '0);
        head      = s_q.mem[s_q.rd_ptr];
        flag_word = 8'h00;
        flag_word[asfc_pkg::FLAG_EMPTY] = empty;
        flag_word[asfc_pkg::FLAG_WMARK] = active && (s_q.count >= target); // see RQ11
        flag_word[asfc_pkg::FLAG_LOST]  = active && s_q.lost; // see RQ11
        axi_awready = !s_q.aw_have && !s_q.bvalid;
        axi_wready  = !s_q.w_have && !s_q.bvalid;
        axi_arready = !s_q.rvalid;
        aw_hs    = axi_req.awvalid && axi_awready;
        w_hs     = axi_req.wvalid && axi_wready;
        ar_hs    = axi_req.arvalid && axi_arready;
        do_write = s_q.aw_have && s_q.w_have;
        wr_idx   = reg_idx(s_q.aw_addr);
        rd_idx   = reg_idx(axi_req.araddr);
    end

    // Next state
    always_comb begin
        logic             pop;
        logic             push;
        logic             drop_old;
        logic             dropped;
        logic             clr_lost;
        logic [31:0]      rd_v;
        logic [31:0]      merged;
        logic [CNT_W-1:0] cnt_n;
        logic [asfc_pkg::IRQ_W-1:0] ev;
        pop      = 1'b0;
        push     = 1'b0;
        drop_old = 1'b0;
        dropped  = 1'b0;
        clr_lost = 1'b0;
        rd_v     = 32'h0;
        merged   = 32'h0;
        cnt_n    = s_q.count;
        ev       = '0;
        s_d      = s_q;

        // Read channel and the side effects of a read
        if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = is_mapped(axi_req.araddr) ? asfc_pkg::RESP_OKAY
                                                   : asfc_pkg::RESP_SLVERR;
            if (is_mapped(axi_req.araddr)) begin
                unique case (rd_idx)
                    asfc_pkg::IDX_CTRL: begin
                        rd_v = {8'h00, s_q.ctrl}; // see RQ12
                    end
                    asfc_pkg::IDX_FLAGS: begin
                        rd_v     = {24'h0, flag_word};
                        clr_lost = 1'b1;
                    end
                    asfc_pkg::IDX_CONV: begin
                        rd_v = 32'(s_q.conv); // see RQ1
                    end
                    asfc_pkg::IDX_STREAM: begin
                        if (s_q.phase == asfc_pkg::PH_IDLE
                            && s_q.ctrl[asfc_pkg::CTRL_STATUS]) begin
                            rd_v     = {24'h0, flag_word}; // see RQ8
                            clr_lost = 1'b1;
                            s_d.phase = s_q.ctrl[asfc_pkg::CTRL_TAG] ? asfc_pkg::PH_TAG
                                                                     : asfc_pkg::PH_DATA;
                        end else if (empty) begin
                            rd_v      = 32'h0;
                            s_d.phase = asfc_pkg::PH_IDLE;
                        end else if (s_q.phase != asfc_pkg::PH_DATA
                                     && s_q.ctrl[asfc_pkg::CTRL_TAG]) begin
                            rd_v      = 32'(head[ENT_W-1:SMP_W]); // see RQ7
                            s_d.phase = asfc_pkg::PH_DATA; // see RQ9
                        end else begin
                            rd_v = 32'(head[SMP_W-1:0]);
                            pop  = 1'b1; // see RQ3
                            s_d.phase = s_q.ctrl[asfc_pkg::CTRL_TAG] ? asfc_pkg::PH_TAG
                                                                     : asfc_pkg::PH_DATA;
                        end
                    end
                    asfc_pkg::IDX_IRQ_ST: begin
                        rd_v = 32'(s_q.irq_st);
                    end
                    default: begin
                        rd_v = 32'(s_q.irq_mask);
                    end
                endcase
            end
            s_d.rdata = rd_v;
        end

        // Conversion intake
        if (conv_valid) begin
            s_d.conv = conv_data;
            if (active) begin
                if (streaming) begin
                    push     = 1'b1; // see RQ5
                    drop_old = full && !pop; // see RQ6
                end else if (!s_q.lock) begin
                    push = 1'b1; // see RQ2
                end else begin
                    dropped = 1'b1; // see RQ4
                end
            end
        end
        if (push) begin
            s_d.mem[s_q.wr_ptr] = {conv_tag, conv_data};
            s_d.wr_ptr = s_q.wr_ptr + PTR_W'(1);
        end
        if (pop || drop_old) begin
            s_d.rd_ptr = s_q.rd_ptr + PTR_W'(1);
        end
        cnt_n = s_q.count + CNT_W'(push && !drop_old) - CNT_W'(pop);
        s_d.count = cnt_n;
        if (!streaming && push && cnt_n >= target) begin
            s_d.lock = 1'b1; // see RQ2
        end else if (cnt_n == '0) begin
            s_d.lock = 1'b0;
        end
        if (pop && cnt_n == '0) begin
            s_d.phase = asfc_pkg::PH_IDLE;
        end
        ev[asfc_pkg::IRQ_WMARK] = push && (cnt_n == target) && (s_q.count != target);
        ev[asfc_pkg::IRQ_LOST]  = dropped || drop_old;
        if (clr_lost) begin
            s_d.lost = 1'b0;
        end
        if (dropped || drop_old) begin
            s_d.lost = 1'b1; // see RQ4 see RQ6
        end

        // Write channel
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (aw_hs) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (w_hs) begin
            s_d.w_have = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (do_write) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = is_mapped(s_q.aw_addr) ? asfc_pkg::RESP_OKAY
                                                 : asfc_pkg::RESP_SLVERR;
            if (is_mapped(s_q.aw_addr)) begin
                if (wr_idx == asfc_pkg::IDX_CTRL) begin
                    merged = lane_merge({8'h00, s_q.ctrl}, s_q.w_data, s_q.w_strb);
                    s_d.ctrl = merged[23:0] & asfc_pkg::CTRL_WR_MASK; // see RQ12
                    if (merged[asfc_pkg::CTRL_MODE_HI:asfc_pkg::CTRL_MODE_LO] != mode) begin
                        s_d.count  = '0;
                        s_d.wr_ptr = '0;
                        s_d.rd_ptr = '0;
                        s_d.lock   = 1'b0;
                        s_d.lost   = 1'b0;
                        s_d.phase  = asfc_pkg::PH_IDLE;
                    end
                end else if (wr_idx == asfc_pkg::IDX_IRQ_ST && s_q.w_strb[0]) begin
                    s_d.irq_st = s_q.irq_st & ~s_q.w_data[asfc_pkg::IRQ_W-1:0];
                end else if (wr_idx == asfc_pkg::IDX_IRQ_MASK && s_q.w_strb[0]) begin
                    s_d.irq_mask = s_q.w_data[asfc_pkg::IRQ_W-1:0];
                end
            end
        end
        // Hardware set wins over a same-cycle clear
        s_d.irq_st = s_d.irq_st | ev;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q          <= '0;
            s_q.ctrl     <= asfc_pkg::CTRL_RESET; // see RQ1 see RQ7 see RQ8
            s_q.irq_mask <= asfc_pkg::IRQ_MASK_RST;
            s_q.phase    <= asfc_pkg::PH_IDLE;
            s_q.bresp    <= asfc_pkg::RESP_OKAY;
            s_q.rresp    <= asfc_pkg::RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_bvalid = s_q.bvalid;
    assign axi_bresp  = s_q.bresp;
    assign axi_rvalid = s_q.rvalid;
    assign axi_rdata  = s_q.rdata;
    assign axi_rresp  = s_q.rresp;
    assign irq        = |(s_q.irq_st & s_q.irq_mask);

endmodule : asfc_sample_buffer

`default_nettype wire

// ===== tb/asfc_sample_buffer_assertions.sv
// Concurrent checks on the sample buffer bus and interrupt ports.
// Assumes binding into asfc_sample_buffer; sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module asfc_sample_buffer_assertions #(
    parameter int DEPTH = 256,
    parameter int SMP_W = 24,
    parameter int TAG_W = 8
) (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    srst,
    // Register bus
    input wire asfc_pkg::asfc_axi_req_t axi_req,
    input wire logic                    axi_awready,
    input wire logic                    axi_wready,
    input wire logic                    axi_bvalid,
    input wire logic [1:0]              axi_bresp,
    input wire logic                    axi_arready,
    input wire logic                    axi_rvalid,
    input wire logic [31:0]             axi_rdata,
    input wire logic [1:0]              axi_rresp,
    // Conversions and interrupt
    input wire logic                    conv_valid,
    input wire logic [SMP_W-1:0]        conv_data,
    input wire logic [TAG_W-1:0]        conv_tag,
    input wire logic                    irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_reset_idle: assert property ($fell(srst) |-> !axi_bvalid && !axi_rvalid && !irq)
        else $error("bus or interrupt busy after reset");
    a_read_turn: assert property (axi_req.arvalid && axi_arready |=> axi_rvalid)
        else $error("read answer late");
    a_write_turn: assert property (axi_req.awvalid && axi_awready && axi_req.wvalid
        && axi_wready |-> ##2 axi_bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (axi_bvalid && !axi_req.bready |=> axi_bvalid
        && $stable(axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (axi_rvalid && !axi_req.rready |=> axi_rvalid
        && $stable(axi_rdata) && $stable(axi_rresp))
        else $error("read answer dropped");
    a_ar_refuse: assert property (axi_rvalid |-> !axi_arready)
        else $error("read taken while answer pending");
    a_aw_refuse: assert property (axi_bvalid |-> !axi_awready && !axi_wready)
        else $error("write taken while answer pending");
    a_err_zero: assert property (axi_rvalid && axi_rresp == asfc_pkg::RESP_SLVERR
        |-> axi_rdata == 32'h0)
        else $error("error read carries data");
    a_bresp_code: assert property (axi_bvalid |-> axi_bresp == asfc_pkg::RESP_OKAY
        || axi_bresp == asfc_pkg::RESP_SLVERR)
        else $error("bad write response code");
endmodule : asfc_sample_buffer_assertions

bind asfc_sample_buffer asfc_sample_buffer_assertions #(
    .DEPTH(DEPTH), .SMP_W(SMP_W), .TAG_W(TAG_W)
) i_asfc_sample_buffer_assertions (.*);

`default_nettype wire

// ===== tb/asfc_host_model.sv
// Host side AXI4-Lite master with one write and one read task.
// Assumes a single clock; released lines show inverted values.
`timescale 1ns/1ps
`default_nettype none

module asfc_host_model (
    // Clock
    input  wire logic                    core_clk,
    // Request
    output var asfc_pkg::asfc_axi_req_t  req,
    // Answer
    input  wire logic                    awready,
    input  wire logic                    wready,
    input  wire logic                    bvalid,
    input  wire logic [1:0]              bresp,
    input  wire logic                    arready,
    input  wire logic                    rvalid,
    input  wire logic [31:0]             rdata,
    input  wire logic [1:0]              rresp
);
    initial req = '0;

    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge core_clk);
        req <= '{1'b1, a, 1'b1, d, 4'hF, 1'b0, 1'b0, ~a, 1'b0};
        while (!(aw_done && w_done)) begin
            @(posedge core_clk);
            if (req.awvalid && awready) begin
                aw_done = 1'b1;
                req.awvalid <= 1'b0;
                req.awaddr  <= ~a;
            end
            if (req.wvalid && wready) begin
                w_done = 1'b1;
                req.wvalid <= 1'b0;
                req.wdata  <= ~d;
            end
        end
        // Late bready lets a write answer wait
        repeat ($urandom() % 3) @(posedge core_clk);
        req.bready <= 1'b1;
        do @(posedge core_clk); while (!bvalid);
        r = bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        do @(posedge core_clk); while (!arready);
        req.arvalid <= 1'b0;
        req.araddr  <= ~a;
        // Late rready lets a read answer wait
        repeat ($urandom() % 3) @(posedge core_clk);
        req.rready  <= 1'b1;
        do @(posedge core_clk); while (!rvalid);
        d = rdata;
        r = rresp;
        req.rready <= 1'b0;
    endtask : rd
endmodule : asfc_host_model

`default_nettype wire

// ===== tb/test_adc_sample_fifo_control.sv
// Self-checking bench for the sample buffer control block.
// Assumes the host model drives the bus and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_adc_sample_fifo_control;
    localparam int DEPTH = 256;
    logic                    core_clk = 1'b0;
    logic                    srst = 1'b1;
    asfc_pkg::asfc_axi_req_t axi_req;
    logic                    aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq;
    logic [1:0]              b_resp, r_resp, rsp;
    logic [31:0]             r_data, dat;
    logic                    conv_valid = 1'b0;
    logic [23:0]             conv_data = 24'h0;
    logic [7:0]              conv_tag = 8'h0;
    logic [31:0]             smp_q [0:DEPTH+7];
    int                      failures = 0;
    int                      samples_checked = 0;
    int                      cycles = 0;

    always #4 core_clk = ~core_clk;

    asfc_sample_buffer #(.DEPTH(DEPTH), .SMP_W(24), .TAG_W(8)) i_asfc_sample_buffer (
        .core_clk(core_clk), .srst(srst), .axi_req(axi_req), .axi_awready(aw_rdy),
        .axi_wready(w_rdy), .axi_bvalid(b_vld), .axi_bresp(b_resp), .axi_arready(ar_rdy),
        .axi_rvalid(r_vld), .axi_rdata(r_data), .axi_rresp(r_resp), .conv_valid(conv_valid),
        .conv_data(conv_data), .conv_tag(conv_tag), .irq(irq));

    asfc_host_model i_asfc_host_model (
        .core_clk(core_clk), .req(axi_req), .awready(aw_rdy), .wready(w_rdy), .bvalid(b_vld),
        .bresp(b_resp), .arready(ar_rdy), .rvalid(r_vld), .rdata(r_data), .rresp(r_resp));

    function automatic logic [31:0] fw(input int e, input int w, input int l);
        return {29'h0, l[0], w[0], e[0]};
    endfunction : fw

    task automatic rd_chk(input logic [9:0] i, input logic [31:0] e);
        i_asfc_host_model.rd({i, 2'b00}, dat, rsp);
        `CHK({rsp, dat}, {asfc_pkg::RESP_OKAY, e})
    endtask : rd_chk

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        i_asfc_host_model.wr({i, 2'b00}, d, rsp);
        `CHK(rsp, asfc_pkg::RESP_OKAY)
    endtask : wr

    task automatic push(input int i);
        @(posedge core_clk);
        smp_q[i] = $urandom();
        conv_valid <= 1'b1;
        conv_data  <= smp_q[i][23:0];
        conv_tag   <= smp_q[i][31:24];
        @(posedge core_clk);
        conv_valid <= 1'b0;
    endtask : push

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(50));
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        // Reset values, bypass, unmapped place
        rd_chk(asfc_pkg::IDX_CTRL, 32'h00040200);
        rd_chk(asfc_pkg::IDX_FLAGS, fw(1, 0, 0));
        rd_chk(asfc_pkg::IDX_IRQ_MASK, 32'h0);
        push(0);
        rd_chk(asfc_pkg::IDX_CONV, {8'h0, smp_q[0][23:0]});
        rd_chk(asfc_pkg::IDX_FLAGS, fw(1, 0, 0));
        rd_chk(asfc_pkg::IDX_STREAM, 32'h0);
        rd_chk(asfc_pkg::IDX_IRQ_ST, 32'h0);
        i_asfc_host_model.rd(12'h004, dat, rsp);
        `CHK({rsp, dat}, {asfc_pkg::RESP_SLVERR, 32'h0})
        i_asfc_host_model.wr(12'h008, 32'hFFFFFFFF, rsp);
        `CHK(rsp, asfc_pkg::RESP_SLVERR)
        $display("test bypass done");
        // Watermark of four, six conversions
        wr(asfc_pkg::IDX_CTRL, 32'h00010004);
        for (int i = 0; i < 6; i++) push(i);
        rd_chk(asfc_pkg::IDX_IRQ_ST, 32'h3);
        `CHK(irq, 1'b0)
        rd_chk(asfc_pkg::IDX_FLAGS, fw(0, 1, 1));
        rd_chk(asfc_pkg::IDX_FLAGS, fw(0, 1, 0));
        wr(asfc_pkg::IDX_IRQ_MASK, 32'h3);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        for (int i = 0; i < 4; i++) begin
            rd_chk(asfc_pkg::IDX_STREAM, {8'h0, smp_q[i][23:0]});
        end
        rd_chk(asfc_pkg::IDX_FLAGS, fw(1, 0, 0));
        push(6);
        rd_chk(asfc_pkg::IDX_FLAGS, fw(0, 0, 0));
        wr(asfc_pkg::IDX_IRQ_ST, 32'h3);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        $display("test watermark done");
        // Streaming past full depth with flag word and tags
        wr(asfc_pkg::IDX_CTRL, 32'h000E0000);
        rd_chk(asfc_pkg::IDX_CTRL, 32'h000E0000);
        for (int i = 0; i < DEPTH + 3; i++) push(i);
        rd_chk(asfc_pkg::IDX_STREAM, fw(0, 1, 1));
        for (int i = 3; i < DEPTH + 3; i++) begin
            rd_chk(asfc_pkg::IDX_STREAM, {24'h0, smp_q[i][31:24]});
            rd_chk(asfc_pkg::IDX_STREAM, {8'h0, smp_q[i][23:0]});
        end
        rd_chk(asfc_pkg::IDX_FLAGS, fw(1, 0, 0));
        // Second streaming code
        wr(asfc_pkg::IDX_CTRL, 32'h00030001);
        push(0);
        push(1);
        rd_chk(asfc_pkg::IDX_FLAGS, fw(0, 1, 0));
        $display("test streaming done");
        // Mid-run reset returns to bypass with an empty buffer
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        rd_chk(asfc_pkg::IDX_CTRL, 32'h00040200);
        rd_chk(asfc_pkg::IDX_FLAGS, fw(1, 0, 0));
        rd_chk(asfc_pkg::IDX_IRQ_ST, 32'h0);
        `CHK(irq, 1'b0)
        $display("test reset done");
        end_of_test();
    end
endmodule : test_adc_sample_fifo_control

`default_nettype wire
